/* File: rtl/mcard_cfg.svh */
// Constants of the matrix card control block: sizes, memory layout, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MCARD_CFG_SVH
`define MCARD_CFG_SVH

// Relay shift chain shape
`define REG_COUNT      12
`define REG_WIDTH      8

// Identification store layout
`define ROM_DEPTH      16
`define ROM_IDENT_ADDR 0
`define ROM_ROWS_ADDR  1
`define ROM_COLS_ADDR  2
`define ROM_REGS_ADDR  3
`define MATRIX_ROWS    8'h08
`define MATRIX_COLS    8'h0C
`define ROM_BLANK      8'h00

// Timing: reference clock and power-up hold-off
`define REF_CLK_MHZ    10
`define PWRUP_TIME_US  100
`define PWRUP_CYCLES   (`PWRUP_TIME_US * `REF_CLK_MHZ)

`endif

/* File: rtl/mcard_pkg.sv */
// Types shared by the matrix card control modules.
// Assumes nothing beyond a SystemVerilog compiler.
package mcard_pkg;

  // One stored or shifted byte
  typedef logic [7:0] byte_t;

  // Power-up safeguard progress
  typedef enum logic [1:0] {
    PWR_WAIT,
    ARMED,
    LIVE
  } guard_state_t;

endpackage

/* File: rtl/ident_if.sv */
// Carrier between the control core and the identification reader.
// Assumes all events are single ref_clk pulses already synchronised.
interface ident_if;
  logic clkFall;    // Link clock falling edge seen
  logic advLoad;    // Advance-byte falling edge seen
  logic ptrClear;   // Pointer clear level, synchronised
  logic selActive;  // Card selected
  logic serialBit;  // Identification bit to the pin

  modport ctrl   (output clkFall, output advLoad, output ptrClear, output selActive,
                  input serialBit);
  modport reader (input clkFall, input advLoad, input ptrClear, input selActive,
                  output serialBit);
endinterface

/* File: rtl/ident_reader.sv */
// Identification store, byte pointer and parallel-to-serial register.
// Assumes events on the carrier are one-cycle pulses on ref_clk.
`include "mcard_cfg.svh"

module ident_reader #(
  parameter int              ROM_DEPTH  = `ROM_DEPTH,
  parameter mcard_pkg::byte_t IDENT_CODE = 8'hA5  // Arbitrary card code
) (
  input wire logic ref_clk,    // Reference clock
  input wire logic nrst,       // Synchronous reset, active low
  ident_if.reader  bus         // Events in, serial bit out
);

  localparam int PW = $clog2(ROM_DEPTH);

  mcard_pkg::byte_t romMem [ROM_DEPTH];  // Card code and config table
  logic [PW-1:0]    ptr_reg;             // Byte pointer
  mcard_pkg::byte_t shift_reg;           // Parallel-to-serial register
  logic             out_reg;             // Serial output flop

  // ----------------------------------------------------------------
  // Stored contents
  // ----------------------------------------------------------------
  // Fixed table; card code first, then matrix shape [R1]
  always_comb begin
    for (int i = 0; i < ROM_DEPTH; i++) begin
      romMem[i] = `ROM_BLANK;
    end
    romMem[`ROM_IDENT_ADDR] = IDENT_CODE;
    romMem[`ROM_ROWS_ADDR]  = `MATRIX_ROWS;
    romMem[`ROM_COLS_ADDR]  = `MATRIX_COLS;
    romMem[`ROM_REGS_ADDR]  = 8'(`REG_COUNT);
  end

  // ----------------------------------------------------------------
  // Byte pointer
  // ----------------------------------------------------------------
  // Clear wins over advance; wraps at the end of the store
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ptr_reg <= '0;
    end else if (bus.selActive && bus.ptrClear) begin
      ptr_reg <= '0;                   // [R3]
    end else if (bus.selActive && bus.advLoad) begin
      ptr_reg <= ptr_reg + 1'b1;       // [R3]
    end
  end

  // ----------------------------------------------------------------
  // Parallel load and serial shift, MSB first
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      shift_reg <= '0;
    end else if (bus.selActive && bus.advLoad) begin
      shift_reg <= romMem[ptr_reg];    // [R3]
    end else if (bus.selActive && bus.clkFall) begin
      shift_reg <= {shift_reg[6:0], 1'b0};  // [R4]
    end
  end

  // Store only drives while the card is selected [R2]
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= bus.selActive & shift_reg[7];  // [R4]
    end
  end

  assign bus.serialBit = out_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ptr_clear;
    @(posedge ref_clk) disable iff (!nrst)
    bus.selActive && bus.ptrClear |=> ptr_reg == '0;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared"); // [R3]

  property p_ident_load;
    @(posedge ref_clk) disable iff (!nrst)
    bus.selActive && bus.advLoad && !bus.ptrClear
      |=> shift_reg == romMem[$past(ptr_reg)] && ptr_reg == $past(ptr_reg) + 1'b1;
  endproperty
  a_ident_load: assert property (p_ident_load) else $error("byte not loaded"); // [R1]

  property p_ident_shift;
    @(posedge ref_clk) disable iff (!nrst)
    bus.selActive && bus.clkFall && !bus.advLoad
      |=> shift_reg == {$past(shift_reg[6:0]), 1'b0} ##1 out_reg == $past(shift_reg[7]);
  endproperty
  a_ident_shift: assert property (p_ident_shift) else $error("bit not shifted"); // [R4]

  property p_ident_quiet;
    @(posedge ref_clk) disable iff (!nrst)
    !bus.selActive |=> !out_reg;
  endproperty
  a_ident_quiet: assert property (p_ident_quiet) else $error("output while deselected"); // [R2]

endmodule

/* File: rtl/matrix_card_serial_control.sv */
// Serial control core of a dual four-by-twelve relay matrix card.
// Assumes all link lines come from another clock domain and are slow
// against ref_clk; the link clock is sampled, not used as a clock.
//
// Overview of operation
// R1 - Card code and table held in store
// R2 - Card select low enables store readout
// R3 - Pointer, advance and clear pick loaded byte
// R4 - One identification bit per link clock
// R5 - Host keeps clear low after first byte
// R6 - Host reads identification before configuration; the bench sends one train and strobe in the hold-off first
// R7 - Config bits shift through twelve registers
// R8 - Relays change only on strobe
// R9 - One bit drives inverting driver low
// R10 - Outputs held off during power up
// R11 - Gate latch cleared by reset, set by strobe
// R12 - First strobe after delay opens gate
// R13 - Host pulses clear high per sequence
// R14 - Host pulses advance low per byte
// R15 - Host strobes once after full train
// R16 - Chain bit order fixed and documented
// R17 - Eight-bit registers shift on rising clock
`include "mcard_cfg.svh"

module matrix_card_serial_control #(
  parameter int REGS  = `REG_COUNT,   // Registers in the chain
  parameter int WIDTH = `REG_WIDTH    // Bits per register
) (
  input  wire logic                  ref_clk,          // Reference clock, 10 MHz
  input  wire logic                  nrst,             // Power-up reset, active low
  input  wire logic                  cardSelectN,      // Card select, active low
  input  wire logic                  linkClk,          // Mainframe serial clock
  input  wire logic                  nextByteN,        // Advance byte, low pulse
  input  wire logic                  bytePointerClear, // Pointer clear, high pulse
  input  wire logic                  relayData,        // Serial relay bits
  input  wire logic                  strobe,           // Apply config, high pulse
  output logic                       identSerialOut,   // Serial identification bits
  output logic [REGS*WIDTH-1:0]      relayDriveN,      // Drivers, low energises
  output logic                       gateActive        // Output gate state
);

  localparam int NB = REGS * WIDTH;
  localparam int NS = 6;

  // Input bit positions in the synchroniser vectors
  localparam int I_STB = 0;
  localparam int I_DAT = 1;
  localparam int I_CLR = 2;
  localparam int I_ADV = 3;
  localparam int I_CLK = 4;
  localparam int I_SEL = 5;

  logic [NS-1:0]           meta_reg;           // First synchroniser stage
  logic [NS-1:0]           sync_reg;           // Second synchroniser stage
  logic [NS-1:0]           prev_reg;           // Edge history
  logic                    clkRise;            // Link clock rising
  logic                    clkFall;            // Link clock falling
  logic                    strobeRise;         // Strobe rising
  logic [WIDTH-1:0]        chain_reg [REGS];   // Cascaded shift registers
  logic [REGS:0]           carry;              // Serial link between registers
  logic [NB-1:0]           chainBits;          // Chain flattened
  logic [NB-1:0]           hold_reg;           // Strobed configuration
  logic [NB-1:0]           drive_reg;          // Driver outputs
  logic [15:0]             pwr_reg;            // Power-up delay counter
  logic                    pwrDone;            // Delay expired
  mcard_pkg::guard_state_t guard_reg;          // Safeguard state
  mcard_pkg::guard_state_t guard_next;         // Safeguard next state
  logic                    gate;               // Output gate enable

  ident_if ib ();                              // Link to identification reader

  // Edge helpers, used for several lines
  function automatic logic rose(input logic now, input logic was);
    return now & ~was;
  endfunction

  function automatic logic fell(input logic now, input logic was);
    return ~now & was;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two flops per line; only prev_reg and logic read the second stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_reg <= 6'h3F;
      sync_reg <= 6'h3F;
      prev_reg <= 6'h3F;
    end else begin
      meta_reg <= {cardSelectN, linkClk, nextByteN, bytePointerClear, relayData, strobe};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign clkRise    = rose(sync_reg[I_CLK], prev_reg[I_CLK]);
  assign clkFall    = fell(sync_reg[I_CLK], prev_reg[I_CLK]);
  assign strobeRise = rose(sync_reg[I_STB], prev_reg[I_STB]);

  // ----------------------------------------------------------------
  // Identification readout
  // ----------------------------------------------------------------
  // Reset value of ones keeps a stray advance edge from firing at start
  assign ib.clkFall   = clkFall;
  assign ib.advLoad   = fell(sync_reg[I_ADV], prev_reg[I_ADV]);   // [R3]
  assign ib.ptrClear  = sync_reg[I_CLR];
  assign ib.selActive = ~sync_reg[I_SEL];                         // [R2]

  ident_reader u_ident (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .bus     (ib.reader)
  );

  assign identSerialOut = ib.serialBit;   // [R4]

  // ----------------------------------------------------------------
  // Relay shift chain
  // ----------------------------------------------------------------
  // First bit sent ends in the top register's MSB [R16]
  assign carry[0] = sync_reg[I_DAT];

  for (genvar g = 0; g < REGS; g++) begin : gChain
    // Shift on link clock rising edge [R17]
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        chain_reg[g] <= '0;
      end else if (clkRise) begin
        chain_reg[g] <= {chain_reg[g][WIDTH-2:0], carry[g]};   // [R7]
      end
    end
    assign carry[g+1]               = chain_reg[g][WIDTH-1];
    assign chainBits[g*WIDTH +: WIDTH] = chain_reg[g];
  end

  // Shifting never touches relays; only the strobe copies [R8]
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_reg <= '0;
    end else if (strobeRise) begin
      hold_reg <= chainBits;   // [R8]
    end
  end

  // ----------------------------------------------------------------
  // Power-up safeguard
  // ----------------------------------------------------------------
  // Stands in for the charging RC; counts once after reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pwr_reg <= '0;
    end else if (!pwrDone) begin
      pwr_reg <= pwr_reg + 1'b1;
    end
  end

  assign pwrDone = (pwr_reg == 16'(`PWRUP_CYCLES));

  // Gate latch: strobes during the delay are ignored, then sticks
  always_comb begin
    guard_next = guard_reg;
    unique case (guard_reg)
      mcard_pkg::PWR_WAIT: if (pwrDone) begin
        guard_next = mcard_pkg::ARMED;                       // [R10]
      end
      mcard_pkg::ARMED: if (strobeRise) begin
        guard_next = mcard_pkg::LIVE;                        // [R12]
      end
      mcard_pkg::LIVE: guard_next = mcard_pkg::LIVE;         // [R11]
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      guard_reg <= mcard_pkg::PWR_WAIT;   // [R11]
    end else begin
      guard_reg <= guard_next;
    end
  end

  assign gate       = (guard_reg == mcard_pkg::LIVE);
  assign gateActive = gate;

  // ----------------------------------------------------------------
  // Inverting relay drivers
  // ----------------------------------------------------------------
  // A one bit pulls its driver low; gate low keeps all released
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      drive_reg <= '1;
    end else begin
      drive_reg <= ~(hold_reg & {NB{gate}});   // [R9] [R10]
    end
  end

  assign relayDriveN = drive_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_chain_shift;
    @(posedge ref_clk) disable iff (!nrst)
    clkRise |=> chain_reg[0][0] == $past(sync_reg[I_DAT])
             && chainBits[NB-1] == $past(chainBits[NB-2]);
  endproperty
  a_chain_shift: assert property (p_chain_shift) else $error("chain did not shift"); // [R7]

  property p_hold_load;
    @(posedge ref_clk) disable iff (!nrst)
    strobeRise |=> hold_reg == $past(chainBits);
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("strobe did not copy"); // [R8]

  property p_hold_still;
    @(posedge ref_clk) disable iff (!nrst)
    !strobeRise |=> $stable(hold_reg);
  endproperty
  a_hold_still: assert property (p_hold_still) else $error("relays moved w/o strobe"); // [R8]

  property p_drive_inv;
    @(posedge ref_clk) disable iff (!nrst)
    gate && $stable(hold_reg) |=> relayDriveN == ~$past(hold_reg);
  endproperty
  a_drive_inv: assert property (p_drive_inv) else $error("driver not inverted"); // [R9]

  property p_safe_pwrup;
    @(posedge ref_clk) disable iff (!nrst)
    !pwrDone |-> !gateActive && relayDriveN == '1;
  endproperty
  a_safe_pwrup: assert property (p_safe_pwrup) else $error("relay on during power up"); // [R10]

  property p_gate_sticky;
    @(posedge ref_clk) disable iff (!nrst)
    gateActive |=> gateActive;
  endproperty
  a_gate_sticky: assert property (p_gate_sticky) else $error("gate dropped"); // [R11]

  sequence s_armed_strobe;
    guard_reg == mcard_pkg::ARMED && strobeRise;
  endsequence

  sequence s_gate_open;
    gateActive [*2];
  endsequence

  property p_gate_set;
    @(posedge ref_clk) disable iff (!nrst)
    s_armed_strobe |=> s_gate_open;
  endproperty
  a_gate_set: assert property (p_gate_set) else $error("strobe did not open gate"); // [R12]

  property p_gate_cause;
    @(posedge ref_clk) disable iff (!nrst)
    $rose(gateActive) |-> $past(strobeRise) && $past(pwrDone);
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate opened w/o strobe"); // [R11]

endmodule

/* File: dv/mainframe_model.sv */
// Mainframe side of the card: drives the serial control lines.
// Assumes ref_clk from the bench; every drive lands 1 ns after a rise.
`include "mcard_cfg.svh"

module mainframe_model (
  input  wire logic ref_clk,          // Bench reference clock
  input  wire logic identSerialOut,   // Identification bits from card
  output logic      cardSelectN,      // Card select, active low
  output logic      linkClk,          // Serial clock, idles high
  output logic      nextByteN,        // Advance byte, low pulse
  output logic      bytePointerClear, // Pointer clear, high pulse
  output logic      relayData,        // Serial relay bits
  output logic      strobe            // Apply configuration
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Link timing
  // ----------------------------------------
  localparam int BITS = `REG_COUNT * `REG_WIDTH; // Chain length
  localparam int HALF = 4;                       // Half link period, 400 ns

  // Idle levels; link clock stands still high between frames
  initial begin
    cardSelectN = 1'b1;
    linkClk = 1'b1;
    nextByteN = 1'b1;
    bytePointerClear = 1'b0;
    relayData = 1'b0;
    strobe = 1'b0;
  end

  // Wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Select or release the card
  task automatic select(input logic on);
    cardSelectN = ~on;
    tick(HALF);
  endtask

  // Start of an identification sequence
  task automatic clear_ptr();
    bytePointerClear = 1'b1;
    tick(HALF);
    bytePointerClear = 1'b0; // Stays low for later bytes
    tick(HALF);
  endtask

  // One identification byte, MSB first
  task automatic read_byte(output mcard_pkg::byte_t b);
    nextByteN = ~nextByteN; // Low pulse from the idle level loads next byte
    tick(HALF);
    nextByteN = ~nextByteN;
    tick(2 * HALF); // Load must reach the pin first
    for (int i = 7; i >= 0; i--) begin
      b[i] = identSerialOut; // Taken late in the high phase
      linkClk = ~linkClk; // Fall from the high idle level
      tick(HALF);
      linkClk = ~linkClk;
      tick(HALF);
    end
  endtask

  // Whole relay train, first bit sent ends highest
  task automatic send_config(input logic [BITS-1:0] v);
    for (int i = BITS - 1; i >= 0; i--) begin
      relayData = v[i];
      linkClk = ~linkClk; // Fall from the high idle level
      tick(HALF);
      linkClk = ~linkClk; // Card takes the bit on this rise
      tick(HALF);
    end
    relayData = ~v[0]; // Flip to the inverse of the last bit: leave no stale level
  endtask

  // Single high pulse after the full train
  task automatic pulse_strobe();
    strobe = ~strobe; // Rise from the low idle level
    tick(HALF);
    strobe = ~strobe;
    tick(HALF);
  endtask
endmodule

/* File: dv/matrix_card_serial_control_tb.sv */
// Self-checking bench of the matrix card control block.
// Assumes the mainframe model drives every link line.
`include "mcard_cfg.svh"

module matrix_card_serial_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int BITS = `REG_COUNT * `REG_WIDTH; // Chain length
  localparam int LIMIT = 20000;                  // Hang ceiling, cycles
  localparam mcard_pkg::byte_t CARD_CODE = 8'hA5; // Arbitrary card code
  logic            ref_clk, nrst, cardSelectN, linkClk, nextByteN;
  logic            bytePointerClear, relayData, strobe;
  logic            identSerialOut, gateActive;
  logic [BITS-1:0] relayDriveN;
  int              fails, checked, cycles;

  // 10 MHz clock
  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  matrix_card_serial_control matrix_card_serial_control_inst (
    .ref_clk(ref_clk), .nrst(nrst), .cardSelectN(cardSelectN), .linkClk(linkClk),
    .nextByteN(nextByteN), .bytePointerClear(bytePointerClear), .relayData(relayData),
    .strobe(strobe), .identSerialOut(identSerialOut), .relayDriveN(relayDriveN),
    .gateActive(gateActive));

  mainframe_model mainframe_model_inst (
    .ref_clk(ref_clk), .identSerialOut(identSerialOut), .cardSelectN(cardSelectN),
    .linkClk(linkClk), .nextByteN(nextByteN), .bytePointerClear(bytePointerClear),
    .relayData(relayData), .strobe(strobe));

  // ----------------------------------------
  // Expectations and reporting
  // ----------------------------------------
  // Stored byte at a pointer value
  function automatic mcard_pkg::byte_t ident_byte(input int k);
    case (k)
      0: return CARD_CODE;
      1: return `MATRIX_ROWS;
      2: return `MATRIX_COLS;
      3: return 8'(`REG_COUNT);
      default: return `ROM_BLANK;
    endcase
  endfunction

  // Compare and count
  task automatic chk(input logic [BITS-1:0] got, input logic [BITS-1:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("Counts: %0d compared, %0d mismatched", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      $display("CHECK FAILED at %0t: run too long", $time);
      results();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [BITS-1:0] cfg;
    logic [BITS-1:0] expDrive;
    mcard_pkg::byte_t got;
    nrst = 1'b0;
    void'($urandom(942));
    repeat (10) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    mainframe_model_inst.tick(1);
    chk(identSerialOut, 0, "ident while deselected");
    chk(relayDriveN, '1, "drivers at power up");
    chk(gateActive, 0, "gate at power up");
    $display("Test power-up done");
    // Strobe inside the hold-off: relays must stay off
    mainframe_model_inst.select(1'b1);
    cfg = {$urandom, $urandom, $urandom};
    mainframe_model_inst.send_config(cfg);
    mainframe_model_inst.pulse_strobe();
    chk(relayDriveN, '1, "early strobe drivers");
    chk(gateActive, 0, "early strobe gate");
    $display("Test early strobe done");
    // Identification read before configuration, then a restart
    mainframe_model_inst.clear_ptr();
    for (int k = 0; k < 5; k++) begin
      mainframe_model_inst.read_byte(got);
      chk(got, ident_byte(k), "ident byte");
    end
    mainframe_model_inst.clear_ptr();
    mainframe_model_inst.read_byte(got);
    chk(got, CARD_CODE, "ident after clear");
    mainframe_model_inst.select(1'b0);
    chk(identSerialOut, 0, "ident after release");
    mainframe_model_inst.select(1'b1);
    $display("Test identification done");
    // Past the hold-off: corner patterns then random ones
    while (cycles < `PWRUP_CYCLES + 40) mainframe_model_inst.tick(1);
    expDrive = '1;
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: cfg = {1'b1, {(BITS - 1){1'b0}}};
        1: cfg = '1;
        2: cfg = '0;
        default: cfg = {$urandom, $urandom, $urandom};
      endcase
      mainframe_model_inst.send_config(cfg);
      chk(relayDriveN, expDrive, "drivers before strobe");
      mainframe_model_inst.pulse_strobe();
      expDrive = ~cfg;
      chk(relayDriveN, expDrive, "drivers after strobe");
      chk(gateActive, 1, "gate after strobe");
    end
    $display("Test configuration done");
    // Second power-up clears the gate; a strobe after one full train, still in the hold-off, stays refused
    nrst = 1'b0;
    mainframe_model_inst.tick(10);
    nrst = 1'b1;
    mainframe_model_inst.tick(1);
    chk(gateActive, 0, "gate after reset");
    // All ones in the chain, so a gate that opened early would show
    mainframe_model_inst.send_config('1);
    mainframe_model_inst.pulse_strobe();
    chk(relayDriveN, '1, "drivers after reset strobe");
    chk(gateActive, 0, "gate after reset strobe");
    $display("Test second power-up done");
    results();
  end
endmodule
